// ===== design/pic_ctrl.sv
`timescale 1ns/1ps

// What this block does
// R1 - eight 16-bit read/write priority registers, four 4-bit fields each
// R2 - field value 0 is lowest level, 0xf is highest, linear between
// R3 - register a sets pins 0-3; register b low fields set pins 6, 7
// R4 - c reserved; d serves timers 0 and 1; e upper fields timer 2
// R5 - f serves serial 1; g converter and compare timers; h watchdog/8-bit timer
// R6 - watchdog and 8-bit timer share one priority field
// R7 - reset clears priority registers; standby leaves them alone
// R8 - reserved priority bits read zero; software writes zero
// R9 - control bit 15 reads live nonmaskable pin level, not writable
// R10 - control bit 8 picks nonmaskable edge: 0 falling, 1 rising
// R11 - control bits 7-4, 1, 0: pin sense, 0 low level, 1 falling edge
// R12 - control bits 14-9, 3, 2 read zero; software writes zero
// R13 - control and flag registers reset; flags reset to zero
// R14 - flag bits 7-4 pins 0-3, bits 1, 0 pins 6, 7; others zero
// R15 - level sense: flag is 1 while pin low, 0 while high
// R16 - edge sense: falling edge sets the flag
// R17 - edge sense: read flag as 1, then write 0 clears it
// R18 - edge sense: flag clears when that pin's request is accepted
// R19 - highest programmed level wins; ties by fixed order
// R20 - request to the cpu only when level exceeds cpu mask
// R21 - cpu abandons decoded instruction, saves status and pc
// R22 - cpu copies level into its mask and jumps through vector
// R23 - edge request held until accepted or cleared; reset discards it
// R24 - equal levels resolve by fixed default ranking
// R25 - nonmaskable is level 16 and ignores the cpu mask
// R26 - writing 1, or 0 without prior read of 1, leaves flag alone
module pic_ctrl (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic nmi_pin,
   input wire logic [5:0] irq_pin_n,
   input wire logic [11:0] periph_req,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [3:0] cpu_mask,
   output logic cpu_irq,
   output logic [4:0] cpu_irq_level,
   output logic [4:0] cpu_irq_src,
   input wire logic cpu_ack,
   input wire logic [4:0] cpu_ack_src
);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [15:0] prio_r [0:7];
   logic [15:0] ctrl_r;
   logic [15:0] rdata_r;
   logic nmi_prev_r;
   logic nmi_prime_r;
   logic nmi_pend_r;
   logic nmi_pend_nxt;
   logic irq_r;
   logic [4:0] lvl_r;
   logic [4:0] src_r;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire prio_hit = (reg_addr < pic_pkg::OFS_CTRL);
   wire [2:0] prio_idx = reg_addr[2:0];
   wire ctrl_wr = reg_wr && (reg_addr == pic_pkg::OFS_CTRL);
   wire flags_wr = reg_wr && (reg_addr == pic_pkg::OFS_FLAGS);
   wire flags_rd = reg_rd && (reg_addr == pic_pkg::OFS_FLAGS);
   wire nmi_edge_sel = ctrl_r[pic_pkg::CTRL_NMI_EDGE_BIT];

   logic [5:0] pin_flag;
   logic [5:0] pin_sense;
   logic [5:0] pin_wbit;
   logic [5:0] pin_ack;
   logic [15:0] flags_view;
   logic [15:0] ctrl_view;
   logic [15:0] rd_mux;

   always_comb
   begin
      flags_view = 16'h0000; // R14
      for (int k = 0; k < pic_pkg::NPIN; k++)
      begin
         pin_sense[k] = ctrl_r[pic_pkg::PIN_BIT[k]]; // R11
         pin_wbit[k] = reg_wdata[pic_pkg::PIN_BIT[k]];
         pin_ack[k] = cpu_ack && (cpu_ack_src == pic_pkg::SRC_PIN0 + 5'(k)) && pin_sense[k];
         flags_view[pic_pkg::PIN_BIT[k]] = pin_flag[k]; // R14
      end
   end

   // live pin level in bit 15, never stored
   assign ctrl_view = {nmi_pin, ctrl_r[14:0] & pic_pkg::CTRL_WMASK[14:0]}; // R9 R12

   assign rd_mux = prio_hit ? prio_r[prio_idx] :
                   (reg_addr == pic_pkg::OFS_CTRL) ? ctrl_view :
                   (reg_addr == pic_pkg::OFS_FLAGS) ? flags_view : 16'h0000;

   // ----------------------------------------
   // pin request flags
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < pic_pkg::NPIN; g++)
      begin : gen_pin
         pic_pin_flag u_pin (
            .sys_clk(sys_clk),
            .rst(rst),
            .pin_n(irq_pin_n[g]),
            .sense_edge(pin_sense[g]),
            .flags_rd(flags_rd),
            .flags_wr(flags_wr),
            .wr_bit(pin_wbit[g]),
            .ack_clr(pin_ack[g]),
            .flag(pin_flag[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // register writes and read data
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < pic_pkg::NPRIO; i++)
         begin
            prio_r[i] <= pic_pkg::PRIO_RESET; // R7
         end
         ctrl_r <= pic_pkg::CTRL_RESET; // R13
         rdata_r <= 16'h0000;
      end
      else
      begin
         if (reg_wr && prio_hit)
         begin
            prio_r[prio_idx] <= reg_wdata & pic_pkg::PRIO_WMASK[prio_idx]; // R1 R8
         end
         if (ctrl_wr)
         begin
            ctrl_r <= reg_wdata & pic_pkg::CTRL_WMASK; // R10 R11 R12
         end
         rdata_r <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   assign reg_rdata = rdata_r;

   // ----------------------------------------
   // nonmaskable pin
   // ----------------------------------------
   wire nmi_hit = nmi_prime_r && (nmi_edge_sel ? (~nmi_prev_r & nmi_pin)
                                               : (nmi_prev_r & ~nmi_pin)); // R10
   wire nmi_ack = cpu_ack && (cpu_ack_src == pic_pkg::SRC_NMI);
   // a fresh edge beside the acceptance stays pending
   assign nmi_pend_nxt = nmi_hit | (nmi_pend_r & ~nmi_ack); // R23

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         nmi_prev_r <= 1'b0;
         nmi_prime_r <= 1'b0;
         nmi_pend_r <= 1'b0;
      end
      else
      begin
         nmi_prev_r <= nmi_pin;
         nmi_prime_r <= 1'b1;
         nmi_pend_r <= nmi_pend_nxt;
      end
   end

   // ----------------------------------------
   // level lookup and arbitration
   // ----------------------------------------
   function automatic logic [4:0] field_level(input logic [15:0] r, input int fld);
      logic [3:0] code;
      code = r[fld*4 +: 4];
      return {1'b0, code}; // R2
   endfunction : field_level

   logic [18:0] req;
   logic [4:0] lvl [0:18];
   logic sel_found;
   logic [4:0] sel_lvl;
   logic [4:0] sel_src;

   always_comb
   begin
      req = {periph_req, pin_flag, nmi_pend_r};
      lvl[0] = pic_pkg::NMI_LEVEL; // R25
      for (int i = 1; i < pic_pkg::NSRC; i++)
      begin
         // both watchdog and 8-bit timer point at register h, field 3
         lvl[i] = field_level(prio_r[pic_pkg::SRC_REG[i]], pic_pkg::SRC_FLD[i]); // R3 R4 R5 R6
      end
      sel_found = 1'b0;
      sel_lvl = 5'h00;
      sel_src = 5'h00;
      // strict compare keeps the earlier, higher ranked source on a tie
      for (int i = 0; i < pic_pkg::NSRC; i++)
      begin
         if (req[i] && (!sel_found || (lvl[i] > sel_lvl))) // R19 R24
         begin
            sel_found = 1'b1;
            sel_lvl = lvl[i];
            sel_src = 5'(i);
         end
      end
   end

   // level 16 always beats a 4-bit mask, so nonmaskable is never gated
   wire grant = sel_found && (sel_lvl > {1'b0, cpu_mask}); // R20 R25

   // ----------------------------------------
   // cpu request
   // ----------------------------------------
   // the request is registered: after an acceptance it stands one more
   // cycle while the raised mask takes effect; a nonmaskable one, never masked, stands two until its cleared pending bit takes effect
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         irq_r <= 1'b0;
         lvl_r <= 5'h00;
         src_r <= 5'h00;
      end
      else
      begin
         irq_r <= grant; // R20
         lvl_r <= grant ? sel_lvl : 5'h00;
         src_r <= grant ? sel_src : 5'h00;
      end
   end

   assign cpu_irq = irq_r;
   assign cpu_irq_level = lvl_r;
   assign cpu_irq_src = src_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_prio_read;
      reg_rd && prio_hit;
   endsequence

   sequence s_ctrl_read;
      reg_rd && (reg_addr == pic_pkg::OFS_CTRL);
   endsequence

   sequence s_read_one0;
      flags_rd && pin_sense[0] && pin_flag[0];
   endsequence

   sequence s_write_zero0;
      flags_wr && !reg_wdata[7] && pin_sense[0] && irq_pin_n[0];
   endsequence

   chk_prio_resv_zero: assert property (s_prio_read |=> // R8
      ((reg_rdata & ~pic_pkg::PRIO_WMASK[$past(prio_idx)]) == 16'h0000))
      else $error("reserved priority bits read nonzero");

   chk_nmi_level_read: assert property (s_ctrl_read |=> // R9
      (reg_rdata[15] == $past(nmi_pin)))
      else $error("control bit 15 does not show pin level");

   chk_ctrl_resv_zero: assert property (s_ctrl_read |=> // R12
      (reg_rdata[14:9] == 6'h00) && (reg_rdata[3:2] == 2'h0))
      else $error("reserved control bits read nonzero");

   chk_mask_gate_on: assert property ((sel_found && (sel_lvl > {1'b0, cpu_mask})) // R20
      |=> cpu_irq && (cpu_irq_level == $past(sel_lvl)))
      else $error("request above mask not raised");

   chk_mask_gate_off: assert property (!(sel_found && (sel_lvl > {1'b0, cpu_mask})) // R20
      |=> !cpu_irq)
      else $error("request at or below mask raised");

   chk_nmi_unmasked: assert property (nmi_pend_r |=> // R25
      cpu_irq && (cpu_irq_level == pic_pkg::NMI_LEVEL) && (cpu_irq_src == pic_pkg::SRC_NMI))
      else $error("nonmaskable request not raised at level 16");

   chk_level_live: assert property (!pin_sense[0] |-> (pin_flag[0] == !irq_pin_n[0])) // R15
      else $error("level flag does not follow pin");

   chk_edge_set: assert property (pin_sense[0] && !ctrl_wr && $fell(irq_pin_n[0]) // R16
      && $past(pin_sense[0])
      |=> pin_flag[0] ##1 (pin_flag[0] || $past(flags_wr || cpu_ack || ctrl_wr)))
      else $error("falling edge did not set flag");

   chk_sw_clear: assert property (s_read_one0 ##1 (!flags_rd && !flags_wr) ##1 s_write_zero0 // R17
      |=> !pin_flag[0])
      else $error("read-one write-zero did not clear flag");

   chk_ack_clear: assert property ((cpu_ack && (cpu_ack_src == pic_pkg::SRC_PIN0) // R18
      && pin_sense[0] && irq_pin_n[0]) |=> !pin_flag[0])
      else $error("acceptance did not clear edge flag");

endmodule : pic_ctrl

// ===== common/pic_pkg.sv
package pic_pkg;

   // ----------------------------------------
   // register map (word index on reg_addr)
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int NPRIO = 8;
   localparam logic [3:0] OFS_PRIO_A = 4'h0;
   localparam logic [3:0] OFS_CTRL = 4'h8;
   localparam logic [3:0] OFS_FLAGS = 4'h9;

   // writable bits of priority_set_a .. priority_set_h; the rest read zero
   localparam logic [15:0] PRIO_WMASK [0:7] = '{
      16'hffff, 16'h00ff, 16'h0000, 16'hffff,
      16'hff00, 16'h000f, 16'hf0ff, 16'hf000};
   localparam logic [15:0] PRIO_RESET = 16'h0000;

   // ----------------------------------------
   // pin_detect_control / pin_request_flags fields
   // ----------------------------------------
   localparam int CTRL_NMI_LEVEL_BIT = 15;
   localparam int CTRL_NMI_EDGE_BIT = 8;
   localparam logic [15:0] CTRL_WMASK = 16'h01f3;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] FLAGS_RESET = 16'h0000;
   localparam int NPIN = 6;
   // pins 0,1,2,3,6,7 in order
   localparam int PIN_BIT [0:5] = '{7, 6, 5, 4, 1, 0};

   // ----------------------------------------
   // sources, listed in default ranking order (index 0 highest)
   // ----------------------------------------
   localparam int NPERIPH = 12;
   localparam int NSRC = 1 + NPIN + NPERIPH;
   localparam int SRC_W = 5;
   localparam int LVL_W = 5;
   localparam logic [4:0] NMI_LEVEL = 5'h10;
   localparam logic [4:0] SRC_NMI = 5'h00;
   localparam logic [4:0] SRC_PIN0 = 5'h01;
   // priority register index and field (3 = bits 15:12 .. 0 = bits 3:0)
   // for each source; index 0 (nonmaskable) is unused here
   localparam int SRC_REG [0:18] = '{
      0, 0, 0, 0, 0, 1, 1,
      3, 3, 3, 3, 4, 4, 5, 6, 6, 6, 7, 7};
   localparam int SRC_FLD [0:18] = '{
      0, 3, 2, 1, 0, 1, 0,
      3, 2, 1, 0, 3, 2, 0, 3, 1, 0, 3, 3};

endpackage : pic_pkg

// ===== design/pic_pin_flag.sv
`timescale 1ns/1ps

// one external request pin: level or falling-edge detection and its flag
module pic_pin_flag (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic pin_n,
   input wire logic sense_edge,
   input wire logic flags_rd,
   input wire logic flags_wr,
   input wire logic wr_bit,
   input wire logic ack_clr,
   output logic flag
);

   logic prev_r;
   logic prime_r;
   logic edge_r;
   logic edge_nxt;
   logic armed_r;
   logic armed_nxt;
   logic fall;
   logic sw_clr;

   // no edge is seen in the first cycle after reset: prev_r is not yet real
   assign fall = prime_r & prev_r & ~pin_n; // R16
   assign sw_clr = flags_wr & ~wr_bit & armed_r; // R17 R26
   // a new edge in the clearing cycle wins over the clear; edges seen under
   // level sense are dropped so a later switch to edge sense starts clean
   assign edge_nxt = sense_edge & (fall | (edge_r & ~sw_clr & ~ack_clr)); // R16 R18 R23
   assign armed_nxt = flags_rd ? flag : (flags_wr ? 1'b0 : armed_r); // R17
   assign flag = sense_edge ? edge_r : ~pin_n; // R15

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         prev_r <= 1'b1;
         prime_r <= 1'b0;
         edge_r <= 1'b0; // R23
         armed_r <= 1'b0;
      end
      else
      begin
         prev_r <= pin_n;
         prime_r <= 1'b1;
         edge_r <= edge_nxt;
         armed_r <= armed_nxt;
      end
   end

endmodule : pic_pin_flag

// ===== testbench/pic_cpu_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// cpu core stand-in: takes requests, answers promptly or slowly
// ----------------------------------------
module pic_cpu_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic accept_en,
   input wire logic slow,
   input wire logic [3:0] mask_in,
   input wire logic cpu_irq,
   input wire logic [4:0] cpu_irq_level,
   input wire logic [4:0] cpu_irq_src,
   output logic [3:0] cpu_mask,
   output logic cpu_ack,
   output logic [4:0] cpu_ack_src
);
   logic [2:0] wait_r;
   logic [1:0] cool_r;

   // cooldown covers the stale request cycle that follows an acceptance, two for a nonmaskable one
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cpu_mask <= 4'h0;
         cpu_ack <= 1'b0;
         cpu_ack_src <= 5'h00;
         wait_r <= 3'h0;
         cool_r <= 2'h0;
      end
      else
      begin
         cpu_ack <= 1'b0;
         if (!accept_en)
            cpu_mask <= mask_in;
         if (cool_r != 2'h0)
            cool_r <= cool_r - 2'h1;
         else if (accept_en && cpu_irq)
         begin
            if (wait_r == (slow ? 3'h4 : 3'h0))
            begin
               cpu_ack <= 1'b1;
               cpu_ack_src <= cpu_irq_src;
               if (cpu_irq_level != 5'h10)
                  cpu_mask <= cpu_irq_level[3:0];
               wait_r <= 3'h0;
               cool_r <= 2'h3;
            end
            else
               wait_r <= wait_r + 3'h1;
         end
         else
            wait_r <= 3'h0;
      end
   end
endmodule : pic_cpu_model

// ===== testbench/pic_ctrl_tb.sv
`timescale 1ns/1ps

module pic_ctrl_tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic nmi_pin = 1'b1;
   logic [5:0] irq_pin_n = 6'h3f;
   logic [11:0] periph_req = 12'h000;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [3:0] cpu_mask;
   logic cpu_irq;
   logic [4:0] cpu_irq_level;
   logic [4:0] cpu_irq_src;
   logic cpu_ack;
   logic [4:0] cpu_ack_src;
   logic accept_en = 1'b0;
   logic slow = 1'b0;
   logic [3:0] mask_in = 4'h0;
   logic [3:0] lvl;
   logic [15:0] rv;
   int n_errors = 0;
   int total_checks = 0;

   always #10 sys_clk = ~sys_clk;

   pic_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .nmi_pin(nmi_pin), .irq_pin_n(irq_pin_n),
      .periph_req(periph_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_mask(cpu_mask), .cpu_irq(cpu_irq),
      .cpu_irq_level(cpu_irq_level), .cpu_irq_src(cpu_irq_src), .cpu_ack(cpu_ack),
      .cpu_ack_src(cpu_ack_src));

   pic_cpu_model i_cpu (.sys_clk(sys_clk), .rst(rst), .accept_en(accept_en), .slow(slow),
      .mask_in(mask_in), .cpu_irq(cpu_irq), .cpu_irq_level(cpu_irq_level),
      .cpu_irq_src(cpu_irq_src), .cpu_mask(cpu_mask), .cpu_ack(cpu_ack),
      .cpu_ack_src(cpu_ack_src));

   // ----------------------------------------
   // bus cycles and comparison
   // ----------------------------------------
   task give_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc

   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   // bounded wait for a request, then its level and source
   task irq_wait(input logic [4:0] l, input logic [4:0] s);
      int i;
      for (i = 0; i < 12 && cpu_irq !== 1'b1; i++)
         cyc(1);
      check("irq", {15'h0, cpu_irq}, 16'h0001);
      check("level", {11'h0, cpu_irq_level}, {11'h0, l});
      check("source", {11'h0, cpu_irq_src}, {11'h0, s});
   endtask : irq_wait

   task ack_wait(input logic [4:0] s);
      int i;
      for (i = 0; i < 20 && cpu_ack !== 1'b1; i++)
         cyc(1);
      check("ack source", {11'h0, cpu_ack_src}, {11'h0, s});
   endtask : ack_wait

   task pulse_pin0;
      @(posedge sys_clk);
      irq_pin_n <= 6'h3e;
      repeat (2) @(posedge sys_clk);
      irq_pin_n <= 6'h3f;
      cyc(2);
   endtask : pulse_pin0

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      give_verdict();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      cyc(2);
      for (int a = 0; a < 11; a++)
      begin
         rd(4'(a), rv);
         check("reset value", rv, (a == 8) ? 16'h8000 : 16'h0000);
      end
      for (int a = 0; a < 11; a++)
      begin
         wr(4'(a), 16'hffff);
         rd(4'(a), rv);
         check("mask", rv, (a < 8) ? pic_pkg::PRIO_WMASK[a] :
            (a == 8) ? (pic_pkg::CTRL_WMASK | 16'h8000) : 16'h0000);
      end
      for (int a = 0; a < 9; a++)
         wr(4'(a), 16'h0000);
      // every source through its own field, pins in level sense
      for (int s = 1; s < 19; s++)
      begin
         lvl = 4'(s % 15 + 1);
         wr(4'(pic_pkg::SRC_REG[s]), {12'h000, lvl} << (4 * pic_pkg::SRC_FLD[s]));
         @(posedge sys_clk);
         if (s < 7)
            irq_pin_n[s - 1] <= 1'b0;
         else
            periph_req[s - 7] <= 1'b1;
         irq_wait({1'b0, lvl}, 5'(s));
         if (s < 7)
         begin
            rd(pic_pkg::OFS_FLAGS, rv);
            check("level flag", rv, 16'h0001 << pic_pkg::PIN_BIT[s - 1]);
         end
         @(posedge sys_clk);
         irq_pin_n <= 6'h3f;
         periph_req <= 12'h000;
         wr(4'(pic_pkg::SRC_REG[s]), 16'h0000);
         cyc(3);
      end
      wr(4'h7, 16'ha000);
      periph_req <= 12'hc00;
      irq_wait(5'h0a, 5'h11);
      @(posedge sys_clk);
      periph_req <= 12'h000;
      wr(4'h7, 16'h0000);
      wr(4'h0, 16'h3500);
      irq_pin_n <= 6'h3c;
      irq_wait(5'h05, 5'h02);
      wr(4'h0, 16'h5500);
      cyc(3);
      check("tie source", {11'h0, cpu_irq_src}, 16'h0001);
      mask_in <= 4'h5;
      cyc(4);
      check("masked", {15'h0, cpu_irq}, 16'h0000);
      mask_in <= 4'h4;
      irq_wait(5'h05, 5'h01);
      @(posedge sys_clk);
      irq_pin_n <= 6'h3f;
      wr(4'h0, 16'h0000);
      // edge sense on pin 0
      wr(pic_pkg::OFS_CTRL, 16'h00f3);
      pulse_pin0();
      wr(pic_pkg::OFS_FLAGS, 16'h0000);
      rd(pic_pkg::OFS_FLAGS, rv);
      check("edge flag", rv, 16'h0080);
      wr(pic_pkg::OFS_FLAGS, 16'h0000);
      rd(pic_pkg::OFS_FLAGS, rv);
      check("cleared flag", rv, 16'h0000);
      mask_in <= 4'hf;
      wr(4'h0, 16'hf000);
      pulse_pin0();
      cyc(4);
      check("equal mask", {15'h0, cpu_irq}, 16'h0000);
      rd(pic_pkg::OFS_FLAGS, rv);
      check("held flag", rv, 16'h0080);
      mask_in <= 4'h0;
      slow <= 1'b1;
      @(posedge sys_clk);
      accept_en <= 1'b1;
      ack_wait(5'h01);
      cyc(3);
      rd(pic_pkg::OFS_FLAGS, rv);
      check("accepted flag", rv, 16'h0000);
      check("cpu mask", {12'h0, cpu_mask}, 16'h000f);
      accept_en <= 1'b0;
      mask_in <= 4'hf;
      wr(4'h0, 16'h0000);
      // nonmaskable, falling then rising edge
      nmi_pin <= 1'b0;
      irq_wait(5'h10, 5'h00);
      rd(pic_pkg::OFS_CTRL, rv);
      check("nmi level", rv, 16'h00f3);
      accept_en <= 1'b1;
      ack_wait(5'h00);
      cyc(6);
      check("nmi done", {15'h0, cpu_irq}, 16'h0000);
      accept_en <= 1'b0;
      wr(pic_pkg::OFS_CTRL, 16'h0100);
      nmi_pin <= 1'b1;
      irq_wait(5'h10, 5'h00);
      // a second reset mid-run must drop the pending nonmaskable request
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      cyc(3);
      check("reset irq", {15'h0, cpu_irq}, 16'h0000);
      check("reset level", {11'h0, cpu_irq_level}, 16'h0000);
      rd(pic_pkg::OFS_CTRL, rv);
      check("reset ctrl", rv, 16'h8000);
      give_verdict();
   end
endmodule : pic_ctrl_tb
